/* File: common/lsm_pkg.sv */
// Purpose: Shared constants for the lightning sensor mode sequencer.
// Assumes: 10 MHz system clock; all rates below are nominal figures.
// Notes: Register addresses and bit positions describe the host-visible images.
package lsm_pkg;
  // System clock
  localparam int unsigned CLK_HZ = 10_000_000;
  // Oscillator targets after trimming
  localparam int unsigned LC_REF_HZ = 500_000;
  localparam int unsigned SYS_OSC_HZ = 1_125_000;
  localparam longint unsigned LOW_OSC_MILLIHZ = 64'd32_260_000;
  // Antenna oscillator start-up and trim time limit
  localparam int unsigned LC_SETTLE_US = 2000;
  localparam int unsigned CAL_LIMIT_US = 2000;
  localparam int unsigned LC_SETTLE_CYC = LC_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CAL_LIMIT_CYC = CAL_LIMIT_US * (CLK_HZ / 1_000_000);
  // Verification dwell times, counted in low-rate oscillator edges
  localparam longint unsigned T_LIGHTNING_MS = 64'd1000;
  localparam longint unsigned T_DISTURBER_MS = 64'd1500;
  localparam int unsigned LIGHT_TICKS = int'(T_LIGHTNING_MS * LOW_OSC_MILLIHZ / 64'd1_000_000);
  localparam int unsigned DIST_TICKS = int'(T_DISTURBER_MS * LOW_OSC_MILLIHZ / 64'd1_000_000);
  // Measurement windows for the trim search
  localparam int unsigned SYS_WIN_LC = 16;
  localparam int unsigned LOW_WIN = 8;
  localparam logic [7:0] SYS_TARGET = 8'(SYS_OSC_HZ * SYS_WIN_LC / LC_REF_HZ);
  localparam logic [7:0] LOW_TARGET =
    8'((64'(LC_REF_HZ) * LOW_WIN * 1000 + LOW_OSC_MILLIHZ / 2) / LOW_OSC_MILLIHZ);
  localparam logic [7:0] SYS_TOL = 8'h02;
  localparam logic [7:0] LOW_TOL = 8'h04;
  // Host-visible register addresses and field positions
  localparam logic [7:0] THRESH_REG = 8'h01;
  localparam logic [7:0] CAUSE_REG = 8'h03;
  localparam logic [7:0] LOW_FLAG_REG = 8'h3A;
  localparam logic [7:0] SYS_FLAG_REG = 8'h3B;
  localparam int unsigned TRIM_OK_BIT = 7;
  localparam int unsigned TRIM_FAIL_BIT = 6;
  localparam logic [3:0] THRESH_RESET = 4'h2;
  // Interrupt cause codes
  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_DISTURBER = 4'h4;
  localparam logic [3:0] CAUSE_LIGHTNING = 4'h8;
  // Positions inside the synchroniser vector
  localparam int unsigned SY_AFE = 0;
  localparam int unsigned SY_IFSEL = 4;
  localparam int unsigned SY_ADDR_LO = 5;
  localparam int unsigned SY_ADDR_HI = 6;
  localparam int unsigned SY_LC = 7;
  localparam int unsigned SY_SYS = 8;
  localparam int unsigned SY_LOW = 9;
  localparam int unsigned SY_VREG = 10;
  localparam int unsigned SYNC_W = 11;
  // Bus address base; arbitrary value
  localparam logic [6:0] I2C_BASE_ADDR = 7'h00;

  typedef enum logic [2:0] {MD_OFF, MD_LISTEN, MD_VERIFY, MD_ENERGY, MD_DWELL} lsm_mode_e;
  typedef enum logic [2:0] {CAL_IDLE, CAL_SETTLE, CAL_MEASURE, CAL_DECIDE, CAL_END} lsm_cal_e;
endpackage

/* File: logic/lsm_mode_ctrl.sv */
// Purpose: Operating-mode sequencer and oscillator trim engine of a lightning sensor.
// Assumes: Pins and oscillator clocks are asynchronous and sampled by mclk.
// Notes: Classification results come from the algorithm block on mclk.
// Behaviour
// - Power-down disables all except host interface; a trim in progress keeps lc_osc_enable and low_osc_enable on
// - Listening keeps front end, watchdog, low-rate oscillator running
// - Watchdog watches front end, alerts classifier
// - Threshold crossing enters signal verification
// - Threshold is host-programmed four-bit field
// - Disturber aborts processing, returns to listening
// - Lightning computes energy, then distance estimate
// - Lightning verification dwell lasts one second
// - Disturber verification dwell lasts 1.5 seconds
// - Interrupt raised on every lightning event
// - Distance reports storm leading edge
// - Select pin chooses SPI or I2C
// - Two address pins choose three addresses
// - Antenna oscillator trims both RC oscillators
// - Trim starts after settling, ends within 2 ms
// - System oscillator trimmed to 1.125 MHz
// - Low-rate oscillator trimmed to 32.26 kHz
// - Interrupt cause in read-only low nibble
// - Trim done and fail flags, bits 7/6
`timescale 1ns/1ps
`default_nettype none
module lsm_mode_ctrl #(
  parameter int unsigned TRIM_W = 5,
  parameter int unsigned ENERGY_W = 21,
  parameter int unsigned DIST_DEPTH = 4,
  parameter int unsigned LIGHT_TICKS = lsm_pkg::LIGHT_TICKS,
  parameter int unsigned DIST_TICKS = lsm_pkg::DIST_TICKS,
  parameter int unsigned LC_SETTLE_CYC = lsm_pkg::LC_SETTLE_CYC,
  parameter int unsigned CAL_LIMIT_CYC = lsm_pkg::CAL_LIMIT_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic power_down,
  input wire logic [3:0] signal_threshold_field,
  input wire logic mask_disturber,
  input wire logic vreg_enable_pin,
  input wire logic [3:0] afe_level,
  input wire logic iface_select_pin,
  input wire logic bus_addr_pin_low,
  input wire logic bus_addr_pin_high,
  input wire logic antenna_lc_osc,
  input wire logic system_rc_osc,
  input wire logic low_rate_rc_osc,
  input wire logic class_done,
  input wire logic class_disturber,
  input wire logic [ENERGY_W-1:0] flash_energy,
  input wire logic [5:0] flash_distance,
  input wire logic irq_ack,
  input wire logic cal_start,
  output logic afe_enable,
  output logic watchdog_enable,
  output logic noise_floor_enable,
  output logic bias_enable,
  output logic low_osc_enable,
  output logic lc_osc_enable,
  output logic regulator_enable,
  output logic algo_enable,
  output logic host_if_enable,
  output logic signal_alert,
  output logic irq,
  output logic [7:0] cause_byte,
  output logic [ENERGY_W-1:0] energy_result,
  output logic [5:0] distance_result,
  output logic spi_selected,
  output logic [6:0] i2c_address,
  output logic i2c_address_valid,
  output logic [TRIM_W-1:0] low_osc_trim,
  output logic [TRIM_W-1:0] sys_osc_trim,
  output logic [7:0] low_osc_status_byte,
  output logic [7:0] sys_osc_status_byte,
  output logic cal_busy
);
  import lsm_pkg::*;

  localparam int unsigned BIT_W = $clog2(TRIM_W);

  // Two-stage synchroniser for every asynchronous input
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [2:0] osc_prev;
  wire [SYNC_W-1:0] raw_in = {vreg_enable_pin, low_rate_rc_osc, system_rc_osc, antenna_lc_osc,
                              bus_addr_pin_high, bus_addr_pin_low, iface_select_pin, afe_level};

  always_ff @(posedge mclk)
  begin
    sync_a <= raw_in;
    sync_b <= sync_a;
    osc_prev <= sync_b[SY_LOW:SY_LC];
  end

  wire lc_edge = sync_b[SY_LC] & ~osc_prev[0];
  wire sys_edge = sync_b[SY_SYS] & ~osc_prev[1];
  wire low_edge = sync_b[SY_LOW] & ~osc_prev[2];

  // Host protocol selection and bus address from straps
  assign spi_selected = ~sync_b[SY_IFSEL];
  wire [1:0] addr_code = {sync_b[SY_ADDR_HI], sync_b[SY_ADDR_LO]};
  assign i2c_address_valid = |addr_code;
  assign i2c_address = I2C_BASE_ADDR | {5'h00, addr_code};

  // Threshold watchdog
  lsm_mode_e mode;
  lsm_mode_e next_mode;
  logic above_prev;
  wire [3:0] afe_sync = sync_b[SY_AFE+3:SY_AFE];
  wire above = afe_sync > signal_threshold_field;
  wire listening = mode == MD_LISTEN;
  wire crossing = listening & above & ~above_prev;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      above_prev <= 1'b0;
      signal_alert <= 1'b0;
    end
    else
    begin
      above_prev <= above & listening;
      signal_alert <= crossing;
    end
  end

  // Mode sequencing
  logic [16:0] dwell_cnt;
  logic [16:0] dwell_limit;
  wire dwell_done = (dwell_cnt >= dwell_limit);
  wire is_disturber = (mode == MD_VERIFY) & class_done & class_disturber;
  wire is_lightning = mode == MD_ENERGY;

  always_comb
  begin
    next_mode = mode;
    case (mode)
      MD_OFF:
        if (!power_down)
          next_mode = MD_LISTEN;
      MD_LISTEN:
        if (crossing)
          next_mode = MD_VERIFY;
      MD_VERIFY:
        if (class_done)
          next_mode = class_disturber ? MD_DWELL : MD_ENERGY;
      MD_ENERGY:
        next_mode = MD_DWELL;
      MD_DWELL:
        if (dwell_done)
          next_mode = MD_LISTEN;
      default:
        next_mode = MD_OFF;
    endcase
    if (power_down)
      next_mode = MD_OFF;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      mode <= MD_OFF;
    else
      mode <= next_mode;
  end

  // Dwell counted in low-rate oscillator edges
  always_ff @(posedge mclk)
  begin
    if (sys_rst || mode != MD_DWELL)
      dwell_cnt <= 17'h0_0000;
    else if (low_edge && !dwell_done)
      dwell_cnt <= dwell_cnt + 17'h0_0001;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      dwell_limit <= 17'(LIGHT_TICKS);
    else if (is_disturber)
      dwell_limit <= 17'(DIST_TICKS);
    else if (is_lightning)
      dwell_limit <= 17'(LIGHT_TICKS);
  end

  // Block enables per mode
  wire active = mode != MD_OFF;
  assign afe_enable = active;
  assign watchdog_enable = active;
  assign noise_floor_enable = active;
  assign bias_enable = active;
  assign low_osc_enable = active | cal_busy;
  assign regulator_enable = active & sync_b[SY_VREG];
  assign algo_enable = (mode == MD_VERIFY) | is_lightning;
  assign host_if_enable = 1'b1;

  // Energy and storm leading-edge distance
  logic [5:0] dist_hist [DIST_DEPTH];
  logic [DIST_DEPTH-1:0] hist_valid;
  logic [5:0] edge_dist;

  always_comb
  begin
    edge_dist = flash_distance;
    for (int i = 0; i < DIST_DEPTH; i++)
      if (hist_valid[i] && dist_hist[i] < edge_dist)
        edge_dist = dist_hist[i];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      hist_valid <= '0;
    else if (is_lightning)
      hist_valid <= {hist_valid[DIST_DEPTH-2:0], 1'b1};
  end

  always_ff @(posedge mclk)
  begin
    if (is_lightning)
    begin
      dist_hist[0] <= flash_distance;
      for (int i = 1; i < DIST_DEPTH; i++)
        dist_hist[i] <= dist_hist[i-1];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      energy_result <= '0;
      distance_result <= 6'h00;
    end
    else if (is_lightning)
    begin
      energy_result <= flash_energy;
      distance_result <= edge_dist;
    end
  end

  // Interrupt and cause field; a new event wins over an acknowledge
  wire dist_irq = is_disturber & ~mask_disturber;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      irq <= 1'b0;
      cause_byte <= 8'h00;
    end
    else if (is_lightning)
    begin
      irq <= 1'b1;
      cause_byte <= {4'h0, CAUSE_LIGHTNING};
    end
    else if (dist_irq)
    begin
      irq <= 1'b1;
      cause_byte <= {4'h0, CAUSE_DISTURBER};
    end
    else if (irq_ack)
    begin
      irq <= 1'b0;
      cause_byte <= {4'h0, CAUSE_NONE};
    end
  end

  // Oscillator trimming against the antenna oscillator
  lsm_cal_e cal_state;
  logic [BIT_W-1:0] trim_bit;
  logic final_pass;
  logic [15:0] cal_timer;
  logic [4:0] lc_win;
  logic [7:0] sys_cnt;
  logic [3:0] low_win;
  logic [7:0] lc_cnt;
  wire sys_win_done = lc_win == 5'(SYS_WIN_LC);
  wire low_win_done = low_win == 4'(LOW_WIN + 1);
  wire sys_fast = sys_cnt > SYS_TARGET;
  wire low_fast = lc_cnt < LOW_TARGET;
  wire [7:0] sys_err = sys_fast ? sys_cnt - SYS_TARGET : SYS_TARGET - sys_cnt;
  wire [7:0] low_err = low_fast ? LOW_TARGET - lc_cnt : lc_cnt - LOW_TARGET;
  wire cal_timeout = cal_timer >= 16'(CAL_LIMIT_CYC);
  wire measuring = cal_state == CAL_MEASURE;
  wire [TRIM_W-1:0] bit_mask = TRIM_W'(1) << trim_bit;
  wire [TRIM_W-1:0] next_bit_mask = bit_mask >> 1;

  assign cal_busy = cal_state != CAL_IDLE && cal_state != CAL_END;
  assign lc_osc_enable = cal_busy;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || cal_state == CAL_DECIDE || cal_state == CAL_SETTLE)
    begin
      lc_win <= 5'h00;
      sys_cnt <= 8'h00;
      low_win <= 4'h0;
      lc_cnt <= 8'h00;
    end
    else if (measuring)
    begin
      if (lc_edge && !sys_win_done)
        lc_win <= lc_win + 5'h01;
      if (sys_edge && !sys_win_done)
        sys_cnt <= sys_cnt + 8'h01;
      if (low_edge && !low_win_done)
        low_win <= low_win + 4'h1;
      if (lc_edge && low_win != 4'h0 && !low_win_done)
        lc_cnt <= lc_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || cal_start)
    begin
      cal_state <= sys_rst ? CAL_IDLE : CAL_SETTLE;
      cal_timer <= 16'h0000;
      trim_bit <= BIT_W'(TRIM_W - 1);
      final_pass <= 1'b0;
      sys_osc_trim <= TRIM_W'(1) << (TRIM_W - 1);
      low_osc_trim <= TRIM_W'(1) << (TRIM_W - 1);
      low_osc_status_byte <= 8'h00;
      sys_osc_status_byte <= 8'h00;
    end
    else
    begin
      case (cal_state)
        CAL_SETTLE:
          if (cal_timer >= 16'(LC_SETTLE_CYC))
          begin
            cal_timer <= 16'h0000;
            cal_state <= CAL_MEASURE;
          end
          else
            cal_timer <= cal_timer + 16'h0001;
        CAL_MEASURE:
          if (cal_timeout)
          begin
            low_osc_status_byte[TRIM_FAIL_BIT] <= 1'b1;
            sys_osc_status_byte[TRIM_FAIL_BIT] <= 1'b1;
            cal_state <= CAL_END;
          end
          else
          begin
            cal_timer <= cal_timer + 16'h0001;
            if (sys_win_done && low_win_done)
              cal_state <= CAL_DECIDE;
          end
        CAL_DECIDE:
        begin
          cal_timer <= cal_timer + 16'h0001;
          if (final_pass)
          begin
            sys_osc_status_byte[TRIM_OK_BIT] <= sys_err <= SYS_TOL;
            sys_osc_status_byte[TRIM_FAIL_BIT] <= sys_err > SYS_TOL;
            low_osc_status_byte[TRIM_OK_BIT] <= low_err <= LOW_TOL;
            low_osc_status_byte[TRIM_FAIL_BIT] <= low_err > LOW_TOL;
            cal_state <= CAL_END;
          end
          else
          begin
            // Successive approximation: drop the bit that made the clock too fast
            sys_osc_trim <= (sys_fast ? sys_osc_trim & ~bit_mask : sys_osc_trim) | next_bit_mask;
            low_osc_trim <= (low_fast ? low_osc_trim & ~bit_mask : low_osc_trim) | next_bit_mask;
            if (trim_bit == '0)
              final_pass <= 1'b1;
            else
              trim_bit <= trim_bit - BIT_W'(1);
            cal_state <= CAL_MEASURE;
          end
        end
        CAL_IDLE, CAL_END:
          cal_state <= cal_state;
        default:
          cal_state <= CAL_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: bench/lsm_mode_ctrl_chk.sv */
// Purpose: Port checks for the mode sequencer.
// Assumes: One clock domain, bound to every lsm_mode_ctrl.
// Notes: Trim time bound follows the instance parameters.
`timescale 1ns/1ps
`default_nettype none
module lsm_mode_ctrl_chk
  import lsm_pkg::*;
#(
  parameter int unsigned LC_SETTLE_CYC = 50,
  parameter int unsigned CAL_LIMIT_CYC = 2000
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic power_down,
  input wire logic irq_ack,
  input wire logic afe_enable,
  input wire logic watchdog_enable,
  input wire logic noise_floor_enable,
  input wire logic bias_enable,
  input wire logic low_osc_enable,
  input wire logic lc_osc_enable,
  input wire logic algo_enable,
  input wire logic host_if_enable,
  input wire logic signal_alert,
  input wire logic irq,
  input wire logic [7:0] cause_byte,
  input wire logic [7:0] low_osc_status_byte,
  input wire logic [7:0] sys_osc_status_byte,
  input wire logic cal_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  int busy_cyc;
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !cal_busy)
      busy_cyc <= 0;
    else
      busy_cyc <= busy_cyc + 1;
  end
  a_off_gates: assert property ($past(power_down) |-> !afe_enable && !algo_enable && host_if_enable)
    else $error("front end alive in power-down");
  a_listen_set: assert property (afe_enable |->
    watchdog_enable && noise_floor_enable && bias_enable && low_osc_enable)
    else $error("listening block missing");
  a_alert_pulse: assert property (signal_alert |=> !signal_alert)
    else $error("alert longer than one cycle");
  a_alert_verify: assert property (signal_alert && !$past(power_down) |-> algo_enable)
    else $error("alert without verification");
  a_irq_cause: assert property ($rose(irq) |->
    cause_byte == {4'h0, CAUSE_LIGHTNING} || cause_byte == {4'h0, CAUSE_DISTURBER})
    else $error("irq with bad cause");
  a_irq_hold: assert property (irq && !irq_ack && !power_down |=> irq)
    else $error("irq dropped without ack");
  a_ack_clear: assert property (irq && irq_ack && !algo_enable |=> !irq && cause_byte == 8'h00)
    else $error("ack did not clear");
  a_cal_lc: assert property (cal_busy |-> lc_osc_enable && low_osc_enable)
    else $error("reference off during trim");
  a_cal_bound: assert property (cal_busy |-> busy_cyc < int'(LC_SETTLE_CYC + CAL_LIMIT_CYC) + 8)
    else $error("trim too long");
  a_cal_flags: assert property ($fell(cal_busy) |-> (sys_osc_status_byte[7] != sys_osc_status_byte[6])
    && (low_osc_status_byte[7] != low_osc_status_byte[6]) && sys_osc_status_byte[5:0] == 6'h00)
    else $error("bad trim flags");
endmodule
`default_nettype wire

/* File: bench/lsm_host_model.sv */
// Purpose: Host that services the interrupt.
// Assumes: Acts on the falling edge of mclk.
// Notes: slow stretches the service delay.
`timescale 1ns/1ps
`default_nettype none
module lsm_host_model (
  input wire logic mclk,
  input wire logic irq,
  input wire logic [7:0] cause_byte,
  input wire logic [5:0] distance_result,
  input wire logic slow,
  output logic irq_ack,
  output logic [7:0] seen_cause,
  output logic [5:0] seen_dist
);
  initial
  begin
    irq_ack = 1'b0;
    seen_cause = 8'h00;
    seen_dist = 6'h00;
    forever
    begin
      @(negedge mclk);
      if (irq === 1'b1)
      begin
        repeat (slow ? 40 : 4) @(negedge mclk);
        seen_cause = cause_byte;
        seen_dist = distance_result;
        irq_ack = 1'b1;
        @(negedge mclk);
        irq_ack = 1'b0;
        @(negedge mclk);
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/lsm_mode_ctrl_tb.sv */
// Purpose: Self-checking bench of the mode sequencer.
// Assumes: Inputs change on the falling edge.
// Notes: Dwell and trim counts are shortened.
`timescale 1ns/1ps
`default_nettype none
module lsm_mode_ctrl_tb;
  import lsm_pkg::*;
  localparam int LT = 20;
  localparam int DT = 30;
  logic mclk = 0, sys_rst = 1, power_down = 0, mask_disturber = 0, vreg_enable_pin = 0, iface_select_pin = 0;
  logic bus_addr_pin_low = 0, bus_addr_pin_high = 0, antenna_lc_osc = 0, system_rc_osc = 0, low_rate_rc_osc = 0;
  logic class_done = 0, class_disturber = 0, irq_ack, cal_start = 0, lc_run = 1, slow = 0;
  logic [3:0] signal_threshold_field = 4'h2, afe_level = 4'h0;
  logic [20:0] flash_energy = 0, energy_result, exp_en = 0;
  logic [5:0] flash_distance = 0, distance_result, exp_d = 0, seen_dist;
  logic afe_enable, watchdog_enable, noise_floor_enable, bias_enable, low_osc_enable, lc_osc_enable;
  logic regulator_enable, algo_enable, host_if_enable, signal_alert, irq, spi_selected, i2c_address_valid, cal_busy;
  logic [7:0] cause_byte, low_osc_status_byte, sys_osc_status_byte, seen_cause;
  logic [6:0] i2c_address;
  logic [4:0] low_osc_trim, sys_osc_trim;
  logic [31:0] rs = 32'h0000_9cbc;
  logic s;
  int err_total = 0, samples_checked = 0, cyc = 0;
  int hist[$];
  lsm_mode_ctrl #(.LIGHT_TICKS(LT), .DIST_TICKS(DT), .LC_SETTLE_CYC(50), .CAL_LIMIT_CYC(2000)) lsm_mode_ctrl_inst (
    .mclk, .sys_rst, .power_down, .signal_threshold_field, .mask_disturber, .vreg_enable_pin, .afe_level,
    .iface_select_pin, .bus_addr_pin_low, .bus_addr_pin_high, .antenna_lc_osc, .system_rc_osc, .low_rate_rc_osc,
    .class_done, .class_disturber, .flash_energy, .flash_distance, .irq_ack, .cal_start, .afe_enable,
    .watchdog_enable, .noise_floor_enable, .bias_enable, .low_osc_enable, .lc_osc_enable, .regulator_enable,
    .algo_enable, .host_if_enable, .signal_alert, .irq, .cause_byte, .energy_result, .distance_result,
    .spi_selected, .i2c_address, .i2c_address_valid, .low_osc_trim, .sys_osc_trim, .low_osc_status_byte,
    .sys_osc_status_byte, .cal_busy);
  lsm_host_model lsm_host_model_inst (.mclk, .irq, .cause_byte, .distance_result, .slow, .irq_ack,
    .seen_cause, .seen_dist);
  initial forever #50 mclk = ~mclk;
  initial forever #400 low_rate_rc_osc = ~low_rate_rc_osc;
  initial forever #444 system_rc_osc = ~system_rc_osc;
  initial forever #1000 antenna_lc_osc = lc_run & ~antenna_lc_osc;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wd_cross(input logic [3:0] lv, output logic seen);
    seen = 1'b0;
    afe_level = lv;
    repeat (8)
    begin
      @(negedge mclk);
      if (signal_alert === 1'b1)
      begin
        seen = 1'b1;
        chk(algo_enable, 1'b1);
      end
    end
    afe_level = 4'h0;
    repeat (4) @(negedge mclk);
  endtask
  // One watchdog event, classified, then optionally its dwell probed
  task automatic ev(input logic dis, input logic [5:0] d, input logic dw);
    logic fire;
    int m;
    wd_cross(signal_threshold_field + 4'h1, s);
    chk(s, 1'b1);
    rs = xs(rs);
    class_done = 1'b1;
    class_disturber = dis;
    flash_energy = 21'(rs);
    flash_distance = d;
    @(negedge mclk);
    class_done = 1'b0;
    repeat (2) @(negedge mclk);
    if (!dis)
    begin
      hist.push_back(d);
      if (hist.size() > 5)
        void'(hist.pop_front());
      m = 63;
      foreach (hist[i])
        if (hist[i] < m)
          m = hist[i];
      exp_en = 21'(rs);
      exp_d = 6'(m);
    end
    fire = !(dis && mask_disturber);
    chk(irq, fire);
    chk(cause_byte, fire ? {4'h0, dis ? CAUSE_DISTURBER : CAUSE_LIGHTNING} : 8'h00);
    chk(energy_result, exp_en);
    chk(distance_result, exp_d);
    if (dw)
    begin
      repeat (((dis ? DT : LT) - 6) * 8) @(negedge mclk);
      wd_cross(signal_threshold_field + 4'h1, s);
      chk(s, 1'b0);
      repeat (80) @(negedge mclk);
      if (fire)
        chk(seen_cause, {4'h0, dis ? CAUSE_DISTURBER : CAUSE_LIGHTNING});
    end
    $display("event done");
  endtask
  task automatic cal(input logic run);
    int n;
    lc_run = run;
    cal_start = 1'b1;
    @(negedge mclk);
    cal_start = 1'b0;
    chk(lc_osc_enable, 1'b1);
    n = 0;
    while (cal_busy === 1'b1 && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    chk(n > 50 && n < 2060, 1'b1);
    if (!run)
      chk({sys_osc_status_byte, low_osc_status_byte}, 16'h4040);
    else
      chk({sys_osc_status_byte, low_osc_status_byte}, 16'h8040);
    chk({sys_osc_trim, low_osc_trim}, run ? 10'h3E0 : 10'h210);
    $display("trim done");
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    rs = xs(rs);
    signal_threshold_field = 4'(rs % 14 + 1);
    vreg_enable_pin = rs[9];
    repeat (4) @(negedge mclk);
    chk({sys_osc_status_byte, low_osc_status_byte, 3'b000, low_osc_trim}, 24'h00_0010);
    chk(regulator_enable, vreg_enable_pin);
    wd_cross(signal_threshold_field, s);
    chk(s, 1'b0);
    $display("reset done");
    ev(1'b0, 6'd40, 1'b1);
    ev(1'b1, 6'd5, 1'b1);
    mask_disturber = 1'b1;
    slow = 1'b1;
    ev(1'b1, 6'd7, 1'b1);
    mask_disturber = 1'b0;
    ev(1'b0, 6'd30, 1'b0);
    power_down = 1'b1;
    repeat (60) @(negedge mclk);
    chk({afe_enable, low_osc_enable, regulator_enable, algo_enable, host_if_enable}, 5'b00001);
    wd_cross(signal_threshold_field + 4'h1, s);
    chk(s, 1'b0);
    $display("power-down done");
    power_down = 1'b0;
    repeat (3) @(negedge mclk);
    ev(1'b0, 6'd50, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      {iface_select_pin, bus_addr_pin_high, bus_addr_pin_low} = 3'(k);
      repeat (5) @(negedge mclk);
      chk(spi_selected, !k[2]);
      if (k[2])
        chk({i2c_address_valid, i2c_address}, {k[1:0] != 0, I2C_BASE_ADDR + 7'(k[1:0])});
    end
    $display("straps done");
    cal(1'b0);
    cal(1'b1);
    give_verdict();
  end
endmodule
bind lsm_mode_ctrl lsm_mode_ctrl_chk #(.LC_SETTLE_CYC(LC_SETTLE_CYC), .CAL_LIMIT_CYC(CAL_LIMIT_CYC)) chk_inst (
  .mclk, .sys_rst, .power_down, .irq_ack, .afe_enable, .watchdog_enable, .noise_floor_enable, .bias_enable,
  .low_osc_enable, .lc_osc_enable, .algo_enable, .host_if_enable, .signal_alert, .irq, .cause_byte,
  .low_osc_status_byte, .sys_osc_status_byte, .cal_busy);
`default_nettype wire
